//--- verilog/tifc_pkg.sv
// Package with offsets, field layout, thresholds and timing for the thermal and input fault block.
package tifc_pkg;

  // Command codes of the byte-wide settings.
  localparam logic [7:0] TIFC_OFS_OTF_LIMIT = 8'h4F;
  localparam logic [7:0] TIFC_OFS_OT_ACTION = 8'h50;
  localparam logic [7:0] TIFC_OFS_OTW_LIMIT = 8'h51;
  localparam logic [7:0] TIFC_OFS_VIN_OV = 8'h55;
  localparam logic [7:0] TIFC_OFS_TON_WAIT = 8'h60;

  // Field positions and widths.
  localparam int TIFC_OTF_CODE_LSB = 0;
  localparam int TIFC_OTF_CODE_W = 3;
  localparam int TIFC_RESTART_POS = 3;
  localparam int TIFC_OTW_CODE_LSB = 0;
  localparam int TIFC_OTW_CODE_W = 3;
  localparam int TIFC_OVF_SEL_POS = 0;
  localparam int TIFC_TON_CODE_LSB = 0;
  localparam int TIFC_TON_CODE_W = 2;

  // Values held while reset is asserted, before the backup store is copied in.
  localparam logic [2:0] TIFC_OTF_CODE_RST = 3'h0;
  localparam logic TIFC_RESTART_RST = 1'b0;
  localparam logic [2:0] TIFC_OTW_CODE_RST = 3'h0;
  localparam logic TIFC_OVF_SEL_RST = 1'b0;
  localparam logic [1:0] TIFC_TON_CODE_RST = 2'h0;

  // Temperature thresholds in degrees Celsius.
  localparam int TIFC_OTF_BASE_C = 115;
  localparam int TIFC_OTF_STEP_C = 5;

  // Input voltage levels in units of 0.1 V.
  localparam logic [7:0] TIFC_VIN_TRIP_LO_DV = 8'hA9;
  localparam logic [7:0] TIFC_VIN_TRIP_HI_DV = 8'hBA;
  localparam logic [7:0] TIFC_VIN_RELEASE_DV = 8'h87;

  // Timing.
  localparam int TIFC_CLK_HZ = 10_000_000;
  localparam int TIFC_RESTART_MS = 56;
  localparam int TIFC_TON_STEP_US = 500;
  localparam int TIFC_RESTART_CYC = TIFC_RESTART_MS * (TIFC_CLK_HZ / 1000);
  localparam int TIFC_TON_STEP_CYC = TIFC_TON_STEP_US * (TIFC_CLK_HZ / 1_000_000);
  localparam int TIFC_TMR_W = 20;

  typedef enum logic [2:0] {
    TIFC_ST_OFF,
    TIFC_ST_DELAY,
    TIFC_ST_RUN,
    TIFC_ST_RETRY,
    TIFC_ST_LATCH
  } tifc_state_t;

  function automatic logic [7:0] tifc_otf_thresh(input logic [2:0] code);
    tifc_otf_thresh = 8'(TIFC_OTF_BASE_C + TIFC_OTF_STEP_C * int'(code));
  endfunction : tifc_otf_thresh

  function automatic logic [7:0] tifc_otw_thresh(input logic [2:0] code);
    unique case (code)
      3'h0: tifc_otw_thresh = 8'h55;
      3'h1: tifc_otw_thresh = 8'h5F;
      3'h2: tifc_otw_thresh = 8'h64;
      3'h3: tifc_otw_thresh = 8'h69;
      3'h4: tifc_otw_thresh = 8'h6E;
      3'h5: tifc_otw_thresh = 8'h73;
      3'h6: tifc_otw_thresh = 8'h7D;
      3'h7: tifc_otw_thresh = 8'h87;
    endcase
  endfunction : tifc_otw_thresh

endpackage : tifc_pkg

//--- verilog/tifc_cfg_if.sv
// Interface carrying the decoded settings from the register bank to the fault logic.
`timescale 1ns/100ps
interface tifc_cfg_if;
  logic [2:0] thermal_fault_level_code;
  logic restart_en;
  logic [2:0] thermal_warning_level_code;
  logic ov_trip_sel;
  logic [1:0] ton_code;
  logic loaded;

  modport bank (
    output thermal_fault_level_code,
    output restart_en,
    output thermal_warning_level_code,
    output ov_trip_sel,
    output ton_code,
    output loaded
  );

  modport core (
    input thermal_fault_level_code,
    input restart_en,
    input thermal_warning_level_code,
    input ov_trip_sel,
    input ton_code,
    input loaded
  );
endinterface : tifc_cfg_if

//--- verilog/tifc_regs.sv
// Byte-wide settings bank with backup-store load, masked writes and registered reads.
`timescale 1ns/100ps
module tifc_regs
  import tifc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Backup store contents
  input wire logic [7:0] nvm_otf_limit_i,
  input wire logic [7:0] nvm_ot_action_i,
  input wire logic [7:0] nvm_otw_limit_i,
  input wire logic [7:0] nvm_vin_ov_i,
  input wire logic [7:0] nvm_ton_wait_i,
  // Command port
  input wire logic [7:0] cmd_addr_i,
  input wire logic wr_stb_i,
  input wire logic [7:0] wr_data_i,
  input wire logic rd_stb_i,
  output logic [7:0] rd_data_o,
  // Decoded settings
  tifc_cfg_if.bank cfg
);

  logic [2:0] otf_reg, otf_next;
  logic rst_reg, rst_next;
  logic [2:0] otw_reg, otw_next;
  logic ovs_reg, ovs_next;
  logic [1:0] ton_reg, ton_next;
  logic loaded_reg, loaded_next;
  logic [7:0] rd_reg, rd_next;

  always_comb begin
    otf_next = otf_reg;
    rst_next = rst_reg;
    otw_next = otw_reg;
    ovs_next = ovs_reg;
    ton_next = ton_reg;
    loaded_next = 1'b1;
    rd_next = rd_reg;
    if (!loaded_reg) begin
      // The first edge after reset release copies the backup store in.
      otf_next = nvm_otf_limit_i[TIFC_OTF_CODE_LSB +: TIFC_OTF_CODE_W];
      rst_next = nvm_ot_action_i[TIFC_RESTART_POS];
      otw_next = nvm_otw_limit_i[TIFC_OTW_CODE_LSB +: TIFC_OTW_CODE_W];
      ovs_next = nvm_vin_ov_i[TIFC_OVF_SEL_POS];
      ton_next = nvm_ton_wait_i[TIFC_TON_CODE_LSB +: TIFC_TON_CODE_W];
    end else if (wr_stb_i) begin
      // Only the writable field is kept; reserved bits are dropped.
      unique case (cmd_addr_i)
        TIFC_OFS_OTF_LIMIT: otf_next = wr_data_i[TIFC_OTF_CODE_LSB +: TIFC_OTF_CODE_W];
        TIFC_OFS_OT_ACTION: rst_next = wr_data_i[TIFC_RESTART_POS];
        TIFC_OFS_OTW_LIMIT: otw_next = wr_data_i[TIFC_OTW_CODE_LSB +: TIFC_OTW_CODE_W];
        TIFC_OFS_VIN_OV: ovs_next = wr_data_i[TIFC_OVF_SEL_POS];
        TIFC_OFS_TON_WAIT: ton_next = wr_data_i[TIFC_TON_CODE_LSB +: TIFC_TON_CODE_W];
        default: ;
      endcase
    end
    if (rd_stb_i) begin
      rd_next = 8'h00;
      unique case (cmd_addr_i)
        TIFC_OFS_OTF_LIMIT: rd_next[TIFC_OTF_CODE_LSB +: TIFC_OTF_CODE_W] = otf_reg;
        TIFC_OFS_OT_ACTION: rd_next[TIFC_RESTART_POS] = rst_reg;
        TIFC_OFS_OTW_LIMIT: rd_next[TIFC_OTW_CODE_LSB +: TIFC_OTW_CODE_W] = otw_reg;
        TIFC_OFS_VIN_OV: rd_next[TIFC_OVF_SEL_POS] = ovs_reg;
        TIFC_OFS_TON_WAIT: rd_next[TIFC_TON_CODE_LSB +: TIFC_TON_CODE_W] = ton_reg;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      otf_reg <= TIFC_OTF_CODE_RST;
      rst_reg <= TIFC_RESTART_RST;
      otw_reg <= TIFC_OTW_CODE_RST;
      ovs_reg <= TIFC_OVF_SEL_RST;
      ton_reg <= TIFC_TON_CODE_RST;
      loaded_reg <= 1'b0;
      rd_reg <= 8'h00;
    end else begin
      otf_reg <= otf_next;
      rst_reg <= rst_next;
      otw_reg <= otw_next;
      ovs_reg <= ovs_next;
      ton_reg <= ton_next;
      loaded_reg <= loaded_next;
      rd_reg <= rd_next;
    end
  end

  assign rd_data_o = rd_reg;
  assign cfg.thermal_fault_level_code = otf_reg;
  assign cfg.restart_en = rst_reg;
  assign cfg.thermal_warning_level_code = otw_reg;
  assign cfg.ov_trip_sel = ovs_reg;
  assign cfg.ton_code = ton_reg;
  assign cfg.loaded = loaded_reg;

endmodule : tifc_regs

//--- verilog/tifc_timer.sv
// Loadable down counter that pulses once when a loaded interval has run out.
`timescale 1ns/100ps
module tifc_timer #(
  parameter int W = 20
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Control
  input wire logic load_i,
  input wire logic [W-1:0] load_val_i,
  input wire logic stop_i,
  // Status
  output logic done_o
);

  logic [W-1:0] cnt_reg, cnt_next;
  logic busy_reg, busy_next;
  logic done_reg, done_next;

  always_comb begin
    cnt_next = cnt_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (stop_i) begin
      busy_next = 1'b0;
    end else if (load_i) begin
      cnt_next = load_val_i;
      busy_next = 1'b1;
    end else if (busy_reg) begin
      if (cnt_reg <= W'(1)) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end else begin
        cnt_next = cnt_reg - W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign done_o = done_reg;

endmodule : tifc_timer

//--- verilog/tifc_top.sv
// Thermal and input-overvoltage fault logic with turn-on delay sequencing.
`timescale 1ns/100ps
module tifc_top
  import tifc_pkg::*;
#(
  parameter int RESTART_CYC = TIFC_RESTART_CYC,
  parameter int TON_STEP_CYC = TIFC_TON_STEP_CYC
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Backup store contents
  input wire logic [7:0] nvm_otf_limit_i,
  input wire logic [7:0] nvm_ot_action_i,
  input wire logic [7:0] nvm_otw_limit_i,
  input wire logic [7:0] nvm_vin_ov_i,
  input wire logic [7:0] nvm_ton_wait_i,
  // Byte command port
  input wire logic [7:0] cmd_addr_i,
  input wire logic wr_stb_i,
  input wire logic [7:0] wr_data_i,
  input wire logic rd_stb_i,
  output logic [7:0] rd_data_o,
  // Telemetry and start condition
  input wire logic [7:0] die_temp_c_i,
  input wire logic [7:0] power_input_rail_dv_i,
  input wire logic start_cond_i,
  // Status flags and their clears
  input wire logic thermal_fault_clr_i,
  input wire logic thermal_warning_clr_i,
  input wire logic input_overvoltage_clr_i,
  output logic thermal_fault_flag_o,
  output logic thermal_warning_flag_o,
  output logic input_overvoltage_flag_o,
  // Power stage control
  output logic switching_en_o,
  output logic rise_start_o,
  output logic latched_off_o
);

  tifc_cfg_if cfg_if ();

  tifc_regs u_regs (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .nvm_otf_limit_i(nvm_otf_limit_i),
    .nvm_ot_action_i(nvm_ot_action_i),
    .nvm_otw_limit_i(nvm_otw_limit_i),
    .nvm_vin_ov_i(nvm_vin_ov_i),
    .nvm_ton_wait_i(nvm_ton_wait_i),
    .cmd_addr_i(cmd_addr_i),
    .wr_stb_i(wr_stb_i),
    .wr_data_i(wr_data_i),
    .rd_stb_i(rd_stb_i),
    .rd_data_o(rd_data_o),
    .cfg(cfg_if)
  );

  // Comparator state. Settings are read live, so a write moves the levels at once.
  logic ot_fault_cond;
  logic ot_warn_cond;
  logic ov_cond_reg, ov_cond_next;
  logic [7:0] vin_trip_lvl;

  always_comb begin
    ot_fault_cond = die_temp_c_i >= tifc_otf_thresh(cfg_if.thermal_fault_level_code);
    ot_warn_cond = die_temp_c_i >= tifc_otw_thresh(cfg_if.thermal_warning_level_code);
    vin_trip_lvl = cfg_if.ov_trip_sel ? TIFC_VIN_TRIP_HI_DV : TIFC_VIN_TRIP_LO_DV;
    ov_cond_next = ov_cond_reg;
    // Hysteresis keeps the detector from chattering near the trip level.
    if (power_input_rail_dv_i >= vin_trip_lvl) begin
      ov_cond_next = 1'b1;
    end else if (power_input_rail_dv_i < TIFC_VIN_RELEASE_DV) begin
      ov_cond_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ov_cond_reg <= 1'b0;
    end else begin
      ov_cond_reg <= ov_cond_next;
    end
  end

  // Sticky status flags. A clear in the same cycle as a new event loses, so no event is dropped.
  // These flags are the only record; there is no alert line to the host.
  logic otf_flag_reg, otf_flag_next;
  logic otw_flag_reg, otw_flag_next;
  logic ovf_flag_reg, ovf_flag_next;

  always_comb begin
    otf_flag_next = otf_flag_reg;
    otw_flag_next = otw_flag_reg;
    ovf_flag_next = ovf_flag_reg;
    if (thermal_fault_clr_i) begin
      otf_flag_next = 1'b0;
    end
    if (thermal_warning_clr_i) begin
      otw_flag_next = 1'b0;
    end
    if (input_overvoltage_clr_i) begin
      ovf_flag_next = 1'b0;
    end
    if (ot_fault_cond) begin
      otf_flag_next = 1'b1;
    end
    if (ot_warn_cond) begin
      otw_flag_next = 1'b1;
    end
    if (ov_cond_reg) begin
      ovf_flag_next = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      otf_flag_reg <= 1'b0;
      otw_flag_reg <= 1'b0;
      ovf_flag_reg <= 1'b0;
    end else begin
      otf_flag_reg <= otf_flag_next;
      otw_flag_reg <= otw_flag_next;
      ovf_flag_reg <= ovf_flag_next;
    end
  end

  // One timer serves both the turn-on delay and the restart wait; they never overlap.
  logic tmr_load;
  logic tmr_stop;
  logic [TIFC_TMR_W-1:0] tmr_val;
  logic tmr_done;
  logic [TIFC_TMR_W-1:0] ton_cycles;

  assign ton_cycles = TIFC_TMR_W'((int'(cfg_if.ton_code) + 1) * TON_STEP_CYC);

  tifc_timer #(
    .W(TIFC_TMR_W)
  ) u_timer (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .load_i(tmr_load),
    .load_val_i(tmr_val),
    .stop_i(tmr_stop),
    .done_o(tmr_done)
  );

  // Power sequencing.
  tifc_state_t state_reg, state_next;
  logic sw_reg, sw_next;
  logic rise_reg, rise_next;
  logic latch_reg, latch_next;

  always_comb begin
    state_next = state_reg;
    tmr_load = 1'b0;
    tmr_stop = 1'b0;
    tmr_val = ton_cycles;
    rise_next = 1'b0;
    unique case (state_reg)
      TIFC_ST_OFF: begin
        if (start_cond_i && cfg_if.loaded) begin
          state_next = TIFC_ST_DELAY;
          tmr_load = 1'b1;
        end
      end
      TIFC_ST_DELAY, TIFC_ST_RUN: begin
        if (ov_cond_reg) begin
          state_next = TIFC_ST_LATCH;
          tmr_stop = 1'b1;
        end else if (ot_fault_cond) begin
          tmr_stop = !cfg_if.restart_en;
          tmr_load = cfg_if.restart_en;
          tmr_val = TIFC_TMR_W'(RESTART_CYC);
          state_next = cfg_if.restart_en ? TIFC_ST_RETRY : TIFC_ST_LATCH;
        end else if (!start_cond_i) begin
          state_next = TIFC_ST_OFF;
          tmr_stop = 1'b1;
        end else if (state_reg == TIFC_ST_DELAY && tmr_done) begin
          state_next = TIFC_ST_RUN;
          rise_next = 1'b1;
        end
      end
      TIFC_ST_RETRY: begin
        if (ov_cond_reg) begin
          state_next = TIFC_ST_LATCH;
          tmr_stop = 1'b1;
        end else if (!start_cond_i) begin
          state_next = TIFC_ST_OFF;
          tmr_stop = 1'b1;
        end else if (tmr_done) begin
          // Each retry runs the full turn-on delay again; retries never run out.
          state_next = TIFC_ST_DELAY;
          tmr_load = 1'b1;
        end
      end
      TIFC_ST_LATCH: begin
        // Only dropping the start condition leaves latch-off.
        if (!start_cond_i) begin
          state_next = TIFC_ST_OFF;
        end
      end
      default: begin
        state_next = TIFC_ST_OFF;
      end
    endcase
    sw_next = (state_next == TIFC_ST_RUN);
    latch_next = (state_next == TIFC_ST_LATCH);
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= TIFC_ST_OFF;
      sw_reg <= 1'b0;
      rise_reg <= 1'b0;
      latch_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      sw_reg <= sw_next;
      rise_reg <= rise_next;
      latch_reg <= latch_next;
    end
  end

  assign thermal_fault_flag_o = otf_flag_reg;
  assign thermal_warning_flag_o = otw_flag_reg;
  assign input_overvoltage_flag_o = ovf_flag_reg;
  assign switching_en_o = sw_reg;
  assign rise_start_o = rise_reg;
  assign latched_off_o = latch_reg;

endmodule : tifc_top

//--- tb/tifc_top_sva.sv
// Port-level checker for the thermal and input fault block.
`timescale 1ns/100ps
module tifc_top_sva
  import tifc_pkg::*;
#(
  parameter int RESTART_CYC = TIFC_RESTART_CYC,
  parameter int TON_STEP_CYC = TIFC_TON_STEP_CYC
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Observed ports
  input wire logic [7:0] cmd_addr_i,
  input wire logic rd_stb_i,
  input wire logic [7:0] rd_data_o,
  input wire logic [7:0] die_temp_c_i,
  input wire logic [7:0] power_input_rail_dv_i,
  input wire logic start_cond_i,
  input wire logic thermal_fault_flag_o,
  input wire logic thermal_warning_flag_o,
  input wire logic input_overvoltage_flag_o,
  input wire logic switching_en_o,
  input wire logic rise_start_o,
  input wire logic latched_off_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  logic [7:0] resv_mask;
  logic [15:0] hi_cnt_reg;
  logic [15:0] hi_cnt_next;
  always_comb begin
    case (cmd_addr_i)
      TIFC_OFS_OTF_LIMIT: resv_mask = 8'hF8;
      TIFC_OFS_OT_ACTION: resv_mask = 8'hF7;
      TIFC_OFS_OTW_LIMIT: resv_mask = 8'hF8;
      TIFC_OFS_VIN_OV: resv_mask = 8'hFE;
      TIFC_OFS_TON_WAIT: resv_mask = 8'hFC;
      default: resv_mask = 8'hFF;
    endcase
    hi_cnt_next = !start_cond_i ? 16'h0000 : (hi_cnt_reg == 16'hFFFF) ? hi_cnt_reg : hi_cnt_reg + 16'h0001;
  end
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hi_cnt_reg <= 16'h0000;
    end else begin
      hi_cnt_reg <= hi_cnt_next;
    end
  end
  a_resv_read_zero: assert property (rd_stb_i |=> (rd_data_o & $past(resv_mask)) == 8'h00)
    else $error("reserved or unmapped bits read nonzero");
  a_fault_top_level: assert property (die_temp_c_i >= 8'h96 |=> thermal_fault_flag_o)
    else $error("fault flag missing above highest level");
  a_fault_below_min: assert property (die_temp_c_i < 8'h73 && !thermal_fault_flag_o |=> !thermal_fault_flag_o)
    else $error("fault flag set below lowest level");
  a_warn_top_level: assert property (die_temp_c_i >= 8'h87 |=> thermal_warning_flag_o)
    else $error("warning flag missing above highest level");
  a_warn_below_min: assert property (die_temp_c_i < 8'h55 && !thermal_warning_flag_o |=> !thermal_warning_flag_o)
    else $error("warning flag set below lowest level");
  a_ov_flag_set: assert property (power_input_rail_dv_i >= 8'hBA |-> ##2 input_overvoltage_flag_o)
    else $error("overvoltage flag missing above high trip");
  a_ov_latch_off: assert property ($rose(input_overvoltage_flag_o) && $past(switching_en_o) |-> ##[0:2] latched_off_o)
    else $error("overvoltage did not latch off");
  a_latch_no_switch: assert property (latched_off_o |-> !switching_en_o)
    else $error("switching while latched off");
  a_rise_one_cycle: assert property (rise_start_o |=> !rise_start_o)
    else $error("rise pulse longer than one cycle");
  a_rise_after_delay: assert property (rise_start_o |-> switching_en_o && hi_cnt_reg > TON_STEP_CYC)
    else $error("rise before shortest turn-on delay");
  a_stop_drops: assert property (!start_cond_i |-> ##2 !switching_en_o)
    else $error("switching kept after stop");
  c_rise: cover property (rise_start_o);
  c_latch: cover property ($rose(latched_off_o));
  c_ov: cover property ($rose(input_overvoltage_flag_o));
endmodule : tifc_top_sva

//--- tb/tifc_host_model.sv
// Host-side byte master model driving the settings port.
`timescale 1ns/100ps
module tifc_host_model (
  // Clock
  input wire logic clk_sys_i,
  // Byte port
  output logic [7:0] cmd_addr_o,
  output logic wr_stb_o,
  output logic [7:0] wr_data_o,
  output logic rd_stb_o,
  input wire logic [7:0] rd_data_i
);
  initial begin
    cmd_addr_o = 8'h00;
    wr_stb_o = 1'b0;
    wr_data_o = 8'h00;
    rd_stb_o = 1'b0;
  end
  // Data is scrambled after the strobe so a stale byte can never pass for a fresh one.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    cmd_addr_o <= a;
    wr_data_o <= d;
    wr_stb_o <= 1'b1;
    @(posedge clk_sys_i);
    wr_stb_o <= 1'b0;
    wr_data_o <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    cmd_addr_o <= a;
    rd_stb_o <= 1'b1;
    @(posedge clk_sys_i);
    rd_stb_o <= 1'b0;
    #1;
    d = rd_data_i;
  endtask : rd
endmodule : tifc_host_model

//--- tb/test_thermal_input_fault_config.sv
// Self-checking bench for the thermal and input fault block.
`timescale 1ns/100ps
module test_thermal_input_fault_config
  import tifc_pkg::*;
;
  localparam int RC = 20;
  localparam int TS = 5;
  localparam logic [7:0] OFS [5] = '{TIFC_OFS_OTF_LIMIT, TIFC_OFS_OT_ACTION, TIFC_OFS_OTW_LIMIT,
    TIFC_OFS_VIN_OV, TIFC_OFS_TON_WAIT};
  localparam logic [7:0] FMASK [5] = '{8'h07, 8'h08, 8'h07, 8'h01, 8'h03};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] nvm [5];
  logic [7:0] cmd_addr, wr_data, rd_data, temp, vin, d, w;
  logic wr_stb, rd_stb, start, fclr, wclr, oclr, ff, wf, of, sw, rise, lat;
  int failures = 0;
  int tests_run = 0;
  int seed = 66070;
  int n;
  always #50 clk = ~clk;
  tifc_host_model host (.clk_sys_i(clk), .cmd_addr_o(cmd_addr), .wr_stb_o(wr_stb), .wr_data_o(wr_data),
    .rd_stb_o(rd_stb), .rd_data_i(rd_data));
  tifc_top #(.RESTART_CYC(RC), .TON_STEP_CYC(TS)) DUT (.clk_sys_i(clk), .rst_n_i(rst_n),
    .nvm_otf_limit_i(nvm[0]), .nvm_ot_action_i(nvm[1]), .nvm_otw_limit_i(nvm[2]), .nvm_vin_ov_i(nvm[3]),
    .nvm_ton_wait_i(nvm[4]), .cmd_addr_i(cmd_addr), .wr_stb_i(wr_stb), .wr_data_i(wr_data),
    .rd_stb_i(rd_stb), .rd_data_o(rd_data), .die_temp_c_i(temp), .power_input_rail_dv_i(vin),
    .start_cond_i(start), .thermal_fault_clr_i(fclr), .thermal_warning_clr_i(wclr),
    .input_overvoltage_clr_i(oclr), .thermal_fault_flag_o(ff), .thermal_warning_flag_o(wf),
    .input_overvoltage_flag_o(of), .switching_en_o(sw), .rise_start_o(rise), .latched_off_o(lat));
  function automatic logic [7:0] otw_exp(input int c);
    int t [8] = '{85, 95, 100, 105, 110, 115, 125, 135};
    return 8'(t[c]);
  endfunction : otw_exp
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_byte
  task automatic chk_bit(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : chk_bit
  task automatic temp_probe(input logic [7:0] t, input int c);
    @(posedge clk);
    temp <= t;
    fclr <= 1'b1;
    wclr <= 1'b1;
    @(posedge clk);
    fclr <= 1'b0;
    wclr <= 1'b0;
    #1;
    chk_bit(ff, t >= 8'(115 + 5 * c), "fault flag");
    chk_bit(wf, t >= otw_exp(c), "warning flag");
  endtask : temp_probe
  task automatic ov_probe(input logic [7:0] v, input logic exp);
    @(posedge clk);
    vin <= v;
    repeat (2) @(posedge clk);
    oclr <= 1'b1;
    @(posedge clk);
    oclr <= 1'b0;
    #1;
    chk_bit(of, exp, "overvoltage flag");
  endtask : ov_probe
  task automatic wait_rise(output int cnt);
    cnt = 0;
    do begin
      @(posedge clk);
      #1;
      cnt++;
    end while (rise !== 1'b1 && cnt < 500);
  endtask : wait_rise
  task automatic ot_pulse();
    @(posedge clk);
    temp <= 8'h96;
    @(posedge clk);
    temp <= 8'h00;
    repeat (3) @(posedge clk);
    #1;
  endtask : ot_pulse
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("mismatch at %0t: watchdog expired", $time);
    test_done();
  end
  initial begin
    foreach (nvm[i]) nvm[i] = 8'($random(seed));
    temp = 8'h00;
    vin = 8'h64;
    start = 1'b0;
    fclr = 1'b0;
    wclr = 1'b0;
    oclr = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      host.rd(OFS[i], d);
      chk_byte(d, nvm[i] & FMASK[i], "backup load");
      w = 8'($random(seed));
      host.wr(OFS[i], w);
      host.rd(OFS[i], d);
      chk_byte(d, w & FMASK[i], "write readback");
    end
    host.rd(8'h52, d);
    chk_byte(d, 8'h00, "unmapped read");
    $display("test registers done");
    for (int c = 0; c < 8; c++) begin
      host.wr(TIFC_OFS_OTF_LIMIT, 8'(c));
      host.wr(TIFC_OFS_OTW_LIMIT, 8'(c));
      temp_probe(8'(115 + 5 * c), c);
      temp_probe(8'(114 + 5 * c), c);
      temp_probe(otw_exp(c), c);
      temp_probe(otw_exp(c) - 8'h01, c);
      temp_probe(8'($random(seed)), c);
    end
    temp <= 8'h00;
    $display("test thermal levels done");
    for (int s = 0; s < 2; s++) begin
      host.wr(TIFC_OFS_VIN_OV, 8'(s));
      ov_probe(s ? 8'hB9 : 8'hA8, 1'b0);
      ov_probe(s ? 8'hBA : 8'hA9, 1'b1);
      ov_probe(8'h88, 1'b1);
      ov_probe(8'h86, 1'b0);
    end
    $display("test overvoltage levels done");
    for (int c = 0; c < 4; c++) begin
      host.wr(TIFC_OFS_TON_WAIT, 8'(c));
      @(posedge clk);
      start <= 1'b1;
      wait_rise(n);
      chk_byte(8'(n), 8'((c + 1) * TS + 2), "turn-on delay");
      chk_bit(sw, 1'b1, "switching after rise");
      @(posedge clk);
      start <= 1'b0;
      repeat (3) @(posedge clk);
    end
    $display("test turn-on delay done");
    host.wr(TIFC_OFS_TON_WAIT, 8'h00);
    host.wr(TIFC_OFS_OT_ACTION, 8'h08);
    @(posedge clk);
    start <= 1'b1;
    wait_rise(n);
    for (int r = 0; r < 2; r++) begin
      ot_pulse();
      chk_bit(sw, 1'b0, "switching after fault");
      chk_bit(lat, 1'b0, "no latch with restart");
      wait_rise(n);
      chk_byte(8'(n), 8'(RC + TS - 1), "restart delay");
    end
    host.wr(TIFC_OFS_OT_ACTION, 8'h00);
    ot_pulse();
    repeat (RC + 4 * TS) @(posedge clk);
    #1;
    chk_bit(lat, 1'b1, "latched off");
    chk_bit(sw, 1'b0, "no switching while latched");
    @(posedge clk);
    start <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk_bit(lat, 1'b0, "latch left on enable low");
    @(posedge clk);
    start <= 1'b1;
    wait_rise(n);
    chk_byte(8'(n), 8'(TS + 2), "restart after toggle");
    $display("test thermal response done");
    host.wr(TIFC_OFS_OT_ACTION, 8'h08);
    @(posedge clk);
    vin <= 8'hBA;
    repeat (4) @(posedge clk);
    vin <= 8'h64;
    repeat (RC + 3 * TS) @(posedge clk);
    #1;
    chk_bit(lat, 1'b1, "overvoltage latch");
    chk_bit(sw, 1'b0, "overvoltage stops switching");
    @(posedge clk);
    start <= 1'b0;
    $display("test overvoltage response done");
    test_done();
  end
endmodule : test_thermal_input_fault_config
bind tifc_top tifc_top_sva #(.RESTART_CYC(RESTART_CYC), .TON_STEP_CYC(TON_STEP_CYC)) u_sva (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cmd_addr_i(cmd_addr_i), .rd_stb_i(rd_stb_i), .rd_data_o(rd_data_o),
  .die_temp_c_i(die_temp_c_i), .power_input_rail_dv_i(power_input_rail_dv_i), .start_cond_i(start_cond_i),
  .thermal_fault_flag_o(thermal_fault_flag_o), .thermal_warning_flag_o(thermal_warning_flag_o),
  .input_overvoltage_flag_o(input_overvoltage_flag_o), .switching_en_o(switching_en_o),
  .rise_start_o(rise_start_o), .latched_off_o(latched_off_o));
